// File: ebtc_timer.sv
/*
  Eight-bit timer core with prescaled or external ticks, two compare
  channels with double buffering, wave outputs and AXI4-Lite registers.
  Assumes irq_ack comes from logic on sys_clk and ext_count_pin is asynchronous.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
// Function
// - Clock select zero stops counting
// - Each tick clears, increments or decrements counter
// - Count readable, writable; write beats counting
// - Three-bit wave_mode across both control registers
// - Output actions never alter counting sequence
// - Compare equality sets match flag on tick
// - Enabled set match flag requests interrupt
// - Flag clears on service or written one
// - PWM compare writes buffered, else direct
// - Buffer loads only at top or bottom
// - Force strobe acts on wave only
// - Count write blocks matches next tick
// - Output action change applies at next match
// - Reset clears wave outputs; kept across modes
// - Nonzero action overrides port value; direction kept
// - Zero action leaves wave output unchanged
// - Normal mode counts up, wraps FF to 00
// - Normal overflow flag set when count wraps
// - Bottom 00, max FF, top FF or compare_a
// - Power-off bit halts the timer
`default_nettype none
`include "ebtc_params.svh"
module ebtc_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire ebtc_pkg::ebtc_axi_req_s axi_req,
  output var ebtc_pkg::ebtc_axi_rsp_s axi_rsp,
  input wire logic ext_count_pin,
  input wire logic [2:0] irq_ack,
  output var logic [2:0] irq_req,
  output var ebtc_pkg::ebtc_pins_s wave_pins
);
  ebtc_pkg::ebtc_state_s st_r; // Registered state
  ebtc_pkg::ebtc_state_s st_nxt; // Next state
  ebtc_pkg::ebtc_mode_e mode; // Active counting mode
  logic tick; // One-cycle timer tick
  logic is_pwm; // Fast or phase-correct mode
  logic is_fast; // Fast mode
  logic [7:0] top; // Top of count sequence
  logic match_a; // Live match on channel a
  logic match_b; // Live match on channel b
  logic wr_fire; // Register write happens this cycle
  logic wr_cnt; // Write to count_value
  logic wr_cb; // Write to control_b
  logic force_a; // Force strobe on channel a
  logic force_b; // Force strobe on channel b
  logic ovf_evt; // Overflow event this tick
  logic bot_evt; // Fast mode wrap to bottom
  logic [2:0] flg_clr; // Flag clears this cycle

  // Mode from both control registers; reserved codes count as normal
  assign mode = ebtc_pkg::ebtc_mode_e'({st_r.wgm_hi, st_r.wgm_lo});
  assign is_fast = (mode == ebtc_pkg::EBTC_FAST_FF) || (mode == ebtc_pkg::EBTC_FAST_OCR);
  assign is_pwm = is_fast || (mode == ebtc_pkg::EBTC_PHASE_FF)
                  || (mode == ebtc_pkg::EBTC_PHASE_OCR);
  // Top is max or compare_a by mode
  assign top = ((mode == ebtc_pkg::EBTC_FAST_OCR) || (mode == ebtc_pkg::EBTC_PHASE_OCR))
               ? st_r.ocr_a : `EBTC_MAX;

  // Tick source selection; stopped when select is zero or power is off
  always_comb begin
    tick = 1'b0;
    unique case (ebtc_pkg::ebtc_cs_e'(st_r.cs))
      ebtc_pkg::EBTC_CS_STOP: tick = 1'b0;
      ebtc_pkg::EBTC_CS_DIV1: tick = 1'b1;
      ebtc_pkg::EBTC_CS_DIV8: tick = (st_r.psc & `EBTC_DIV8) == `EBTC_DIV8;
      ebtc_pkg::EBTC_CS_DIV64: tick = (st_r.psc & `EBTC_DIV64) == `EBTC_DIV64;
      ebtc_pkg::EBTC_CS_DIV256: tick = (st_r.psc & `EBTC_DIV256) == `EBTC_DIV256;
      ebtc_pkg::EBTC_CS_DIV1024: tick = (st_r.psc & `EBTC_DIV1024) == `EBTC_DIV1024;
      ebtc_pkg::EBTC_CS_EXT_FALL: tick = ~st_r.ext_sync[1] & st_r.ext_prev;
      ebtc_pkg::EBTC_CS_EXT_RISE: tick = st_r.ext_sync[1] & ~st_r.ext_prev;
    endcase
    if (st_r.pwr_off) begin
      tick = 1'b0;
    end
  end

  // Register write strobes
  assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.rsp.bvalid & st_r.wstb;
  assign wr_cnt = wr_fire && (st_r.awaddr == `EBTC_OFF_COUNT);
  assign wr_cb = wr_fire && (st_r.awaddr == `EBTC_OFF_CTRL_B);
  // Force strobes only in non-PWM modes
  assign force_a = wr_cb && st_r.wdata[`EBTC_CB_FORCE_A] && !is_pwm;
  assign force_b = wr_cb && st_r.wdata[`EBTC_CB_FORCE_B] && !is_pwm;
  // Matches on a tick, suppressed after a count write
  assign match_a = tick && !st_r.blk && (st_r.cnt == st_r.ocr_a);
  assign match_b = tick && !st_r.blk && (st_r.cnt == st_r.ocr_b);
  assign bot_evt = tick && is_fast && (st_r.cnt == top);
  // Flag clears from written ones and from interrupt service
  assign flg_clr = ((wr_fire && (st_r.awaddr == `EBTC_OFF_FLAG))
                    ? st_r.wdata[`EBTC_FL_BITS] : 3'h0) | irq_ack;

  // Overflow event per mode
  always_comb begin
    ovf_evt = 1'b0;
    if (tick) begin
      if (is_fast) begin
        ovf_evt = st_r.cnt == top;
      end else if (is_pwm) begin
        ovf_evt = st_r.down && (st_r.cnt == `EBTC_ONE);
      end else begin
        ovf_evt = st_r.cnt == `EBTC_MAX;
      end
    end
  end

  // Next wave level for one channel
  function automatic logic wave_next(input logic [1:0] act, input logic cur,
                                     input logic match, input logic force_s,
                                     input logic bot, input logic toggle_ok);
    logic w;
    w = cur;
    if (!is_pwm) begin
      if (match || force_s) begin
        unique case (act)
          2'h0: w = cur;
          2'h1: w = ~cur;
          2'h2: w = 1'b0;
          2'h3: w = 1'b1;
        endcase
      end
    end else if (match) begin
      unique case (act)
        2'h0: w = cur;
        2'h1: w = toggle_ok ? ~cur : cur;
        2'h2: w = is_fast ? 1'b0 : st_r.down;
        2'h3: w = is_fast ? 1'b1 : ~st_r.down;
      endcase
    end else if (bot) begin
      if (act == 2'h2) begin
        w = 1'b1;
      end else if (act == 2'h3) begin
        w = 1'b0;
      end
    end
    return w;
  endfunction

  // Whole next-state computation
  always_comb begin
    st_nxt = st_r;
    // Pin synchroniser and edge history
    st_nxt.ext_sync = {st_r.ext_sync[0], ext_count_pin};
    st_nxt.ext_prev = st_r.ext_sync[1];
    // Free-running prescaler while powered
    if (!st_r.pwr_off) begin
      st_nxt.psc = st_r.psc + 10'h001;
    end
    // Counter step per mode; actions play no part here
    if (tick) begin
      st_nxt.blk = 1'b0;
      unique case (mode)
        ebtc_pkg::EBTC_CTC: st_nxt.cnt = (st_r.cnt == st_r.ocr_a)
                                         ? `EBTC_BOTTOM : st_r.cnt + `EBTC_ONE;
        ebtc_pkg::EBTC_FAST_FF, ebtc_pkg::EBTC_FAST_OCR: begin
          st_nxt.cnt = (st_r.cnt == top) ? `EBTC_BOTTOM : st_r.cnt + `EBTC_ONE;
        end
        ebtc_pkg::EBTC_PHASE_FF, ebtc_pkg::EBTC_PHASE_OCR: begin
          if (st_r.down) begin
            st_nxt.down = st_r.cnt != `EBTC_BOTTOM;
            st_nxt.cnt = st_nxt.down ? st_r.cnt - `EBTC_ONE : st_r.cnt + `EBTC_ONE;
          end else begin
            st_nxt.down = st_r.cnt == top;
            st_nxt.cnt = st_nxt.down ? st_r.cnt - `EBTC_ONE : st_r.cnt + `EBTC_ONE;
          end
        end
        default: st_nxt.cnt = st_r.cnt + `EBTC_ONE;
      endcase
    end
    // Buffer transfer at bottom for fast, at top for phase correct
    if (tick && is_pwm && (is_fast ? st_r.cnt == top : (!st_r.down && st_r.cnt == top))) begin
      st_nxt.ocr_a = st_r.buf_a;
      st_nxt.ocr_b = st_r.buf_b;
    end
    if (!is_pwm) begin
      st_nxt.down = 1'b0;
    end
    // Wave outputs; a written action applies at the next match or force
    st_nxt.wave_a = wave_next(st_r.act_a, st_r.wave_a, match_a, force_a, bot_evt,
                              st_r.wgm_hi);
    st_nxt.wave_b = wave_next(st_r.act_b, st_r.wave_b, match_b, force_b, bot_evt, 1'b0);
    // Flags: a set in the same cycle as a clear wins
    st_nxt.flg = (st_r.flg & ~flg_clr) | {match_b, match_a, ovf_evt};
    // Register writes
    if (wr_fire) begin
      unique case (st_r.awaddr)
        `EBTC_OFF_CTRL_A: begin
          st_nxt.wgm_lo = st_r.wdata[`EBTC_CA_WGM_LO];
          st_nxt.act_a = st_r.wdata[`EBTC_CA_ACT_A];
          st_nxt.act_b = st_r.wdata[`EBTC_CA_ACT_B];
        end
        `EBTC_OFF_CTRL_B: begin
          st_nxt.cs = st_r.wdata[`EBTC_CB_CS];
          st_nxt.wgm_hi = st_r.wdata[`EBTC_CB_WGM_HI];
        end
        `EBTC_OFF_COUNT: begin
          st_nxt.cnt = st_r.wdata;
          st_nxt.blk = 1'b1;
        end
        `EBTC_OFF_CMP_A: begin
          st_nxt.buf_a = st_r.wdata;
          if (!is_pwm) begin
            st_nxt.ocr_a = st_r.wdata;
          end
        end
        `EBTC_OFF_CMP_B: begin
          st_nxt.buf_b = st_r.wdata;
          if (!is_pwm) begin
            st_nxt.ocr_b = st_r.wdata;
          end
        end
        `EBTC_OFF_MASK: st_nxt.msk = st_r.wdata[`EBTC_FL_BITS];
        `EBTC_OFF_MISC: begin
          st_nxt.pdir = st_r.wdata[`EBTC_MI_PDIR];
          st_nxt.pval = st_r.wdata[`EBTC_MI_PVAL];
          st_nxt.pwr_off = st_r.wdata[`EBTC_MI_PWR_OFF];
        end
        default: st_nxt.cnt = st_nxt.cnt;
      endcase
    end
    // Interrupt requests from enabled flags
    st_nxt.irq = st_nxt.flg & st_nxt.msk;
    // Pins: wave overrides port value when action is nonzero
    st_nxt.pins.out[0] = (st_nxt.act_a != 2'h0) ? st_nxt.wave_a : st_nxt.pval[0];
    st_nxt.pins.out[1] = (st_nxt.act_b != 2'h0) ? st_nxt.wave_b : st_nxt.pval[1];
    st_nxt.pins.oe = st_nxt.pdir;
    // Write channels: take address and data in either order
    if (axi_req.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_r.rsp.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = axi_req.wdata[7:0];
      st_nxt.wstb = axi_req.wstrb[0];
    end
    // Write response after both halves arrive
    if (st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = (st_r.awaddr[1:0] == 2'h0) && (st_r.awaddr <= `EBTC_OFF_MISC)
                         ? `EBTC_RESP_OKAY : `EBTC_RESP_SLVERR;
    end else if (st_r.rsp.bvalid && axi_req.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end
    // Read channel: data one cycle after the address is taken
    if (axi_req.arvalid && st_r.rsp.arready) begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rresp = `EBTC_RESP_OKAY;
      st_nxt.rsp.rdata = 32'h0000_0000;
      unique case (axi_req.araddr)
        `EBTC_OFF_CTRL_A: st_nxt.rsp.rdata[7:0] = {st_r.act_a, st_r.act_b, 2'h0, st_r.wgm_lo};
        `EBTC_OFF_CTRL_B: st_nxt.rsp.rdata[7:0] = {4'h0, st_r.wgm_hi, st_r.cs};
        `EBTC_OFF_COUNT: st_nxt.rsp.rdata[7:0] = st_r.cnt;
        `EBTC_OFF_CMP_A: st_nxt.rsp.rdata[7:0] = st_r.buf_a;
        `EBTC_OFF_CMP_B: st_nxt.rsp.rdata[7:0] = st_r.buf_b;
        `EBTC_OFF_MASK: st_nxt.rsp.rdata[7:0] = {5'h00, st_r.msk};
        `EBTC_OFF_FLAG: st_nxt.rsp.rdata[7:0] = {5'h00, st_r.flg};
        `EBTC_OFF_MISC: st_nxt.rsp.rdata[7:0] = {3'h0, st_r.pwr_off, st_r.pval, st_r.pdir};
        default: st_nxt.rsp.rresp = `EBTC_RESP_SLVERR;
      endcase
    end else if (st_r.rsp.rvalid && axi_req.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
    end
    // Ready only when the matching slot is free
    st_nxt.rsp.awready = ~st_nxt.aw_got & ~st_nxt.rsp.bvalid;
    st_nxt.rsp.wready = ~st_nxt.w_got & ~st_nxt.rsp.bvalid;
    st_nxt.rsp.arready = ~st_nxt.rsp.rvalid;
  end

  // State register; wave outputs clear on reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.rsp.awready <= 1'b1;
      st_r.rsp.wready <= 1'b1;
      st_r.rsp.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign axi_rsp = st_r.rsp;
  assign irq_req = st_r.irq;
  assign wave_pins = st_r.pins;

  // Checks
  property p_stop;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_r.cs == 3'h0 && !wr_cnt) |=> (st_r.cnt == $past(st_r.cnt));
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");
  property p_incr;
    @(posedge sys_clk) disable iff (!rst_n)
    (tick && mode == ebtc_pkg::EBTC_NORMAL && !wr_cnt) |=> st_r.cnt == $past(st_r.cnt) + 8'h01;
  endproperty
  a_incr: assert property (p_incr) else $error("normal tick did not increment");
  property p_wr_cnt;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_cnt |=> (st_r.cnt == $past(st_r.wdata)) && st_r.blk;
  endproperty
  a_wr_cnt: assert property (p_wr_cnt) else $error("count write lost");
  property p_match;
    @(posedge sys_clk) disable iff (!rst_n)
    (tick && !st_r.blk && st_r.cnt == st_r.ocr_a)
      |=> st_r.flg[1] && (st_r.irq[1] == st_r.msk[1]);
  endproperty
  a_match: assert property (p_match) else $error("match flag not set");
  property p_block;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_r.blk && tick && !st_r.flg[1] && !wr_cnt) |=> !st_r.flg[1];
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");
  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (tick && mode == ebtc_pkg::EBTC_NORMAL && st_r.cnt == 8'hFF && !wr_cnt)
      |=> st_r.cnt == 8'h00 && st_r.flg[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap or overflow wrong");
  property p_force;
    @(posedge sys_clk) disable iff (!rst_n)
    (force_a && st_r.act_a == 2'h3 && !match_a && !st_r.flg[1] && irq_ack[1] == 1'b0)
      |=> st_r.wave_a && wave_pins.out[0] && !st_r.flg[1];
  endproperty
  a_force: assert property (p_force) else $error("force failed");
  property p_pin;
    @(posedge sys_clk) disable iff (!rst_n)
    (wave_pins.out[0] == ((st_r.act_a != 2'h0) ? st_r.wave_a : st_r.pval[0]))
      && (wave_pins.oe == st_r.pdir);
  endproperty
  a_pin: assert property (p_pin) else $error("pin source wrong");
  property p_keep;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_r.act_b == 2'h0) |=> st_r.wave_b == $past(st_r.wave_b);
  endproperty
  a_keep: assert property (p_keep) else $error("wave changed with zero action");
  // Compare registers, power gating and flag writes
  property p_direct;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_fire && st_r.awaddr == `EBTC_OFF_CMP_A && !is_pwm)
      |=> st_r.ocr_a == $past(st_r.wdata);
  endproperty
  a_direct: assert property (p_direct) else $error("direct compare write lost");
  property p_hold_cmp;
    @(posedge sys_clk) disable iff (!rst_n)
    (is_pwm && !(tick && st_r.cnt == top)) |=> st_r.ocr_a == $past(st_r.ocr_a);
  endproperty
  a_hold_cmp: assert property (p_hold_cmp) else $error("compare changed off top");
  property p_power;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_r.pwr_off && !wr_cnt) |=> st_r.cnt == $past(st_r.cnt);
  endproperty
  a_power: assert property (p_power) else $error("counter moved while powered off");
  property p_flag_keep;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_fire && st_r.awaddr == `EBTC_OFF_FLAG && irq_ack == 3'h0)
      |=> ($past(st_r.flg) & ~$past(st_r.wdata[`EBTC_FL_BITS]) & ~st_r.flg) == 3'h0;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost on zero write");
  c_ovf: cover property (@(posedge sys_clk) disable iff (!rst_n) st_r.flg[0]);
  c_force: cover property (@(posedge sys_clk) disable iff (!rst_n) force_a);
  c_pwm: cover property (@(posedge sys_clk) disable iff (!rst_n) tick && is_pwm && match_b);
  c_block: cover property (@(posedge sys_clk) disable iff (!rst_n) st_r.blk && tick);
  c_ack: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_ack != 3'h0);
endmodule
`default_nettype wire

// File: ebtc_params.svh
/*
  Constants of the eight-bit timer core: register offsets, field positions,
  counter limits, prescaler masks and bus responses.
  Assumes inclusion by bare name from the timer design file.
*/
`ifndef EBTC_PARAMS_SVH
`define EBTC_PARAMS_SVH
// Register byte offsets on the register bus
`define EBTC_OFF_CTRL_A 8'h00
`define EBTC_OFF_CTRL_B 8'h04
`define EBTC_OFF_COUNT 8'h08
`define EBTC_OFF_CMP_A 8'h0C
`define EBTC_OFF_CMP_B 8'h10
`define EBTC_OFF_MASK 8'h14
`define EBTC_OFF_FLAG 8'h18
`define EBTC_OFF_MISC 8'h1C
// Field positions in control_a
`define EBTC_CA_WGM_LO 1:0
`define EBTC_CA_ACT_B 5:4
`define EBTC_CA_ACT_A 7:6
// Field positions in control_b
`define EBTC_CB_CS 2:0
`define EBTC_CB_WGM_HI 3
`define EBTC_CB_FORCE_B 6
`define EBTC_CB_FORCE_A 7
// Field positions in flag and mask registers
`define EBTC_FL_BITS 2:0
// Field positions in the misc register
`define EBTC_MI_PDIR 1:0
`define EBTC_MI_PVAL 3:2
`define EBTC_MI_PWR_OFF 4
// Counter limits
`define EBTC_BOTTOM 8'h00
`define EBTC_MAX 8'hFF
`define EBTC_ONE 8'h01
// Prescaler tap masks for divide by 8, 64, 256 and 1024
`define EBTC_DIV8 10'h007
`define EBTC_DIV64 10'h03F
`define EBTC_DIV256 10'h0FF
`define EBTC_DIV1024 10'h3FF
// Bus responses
`define EBTC_RESP_OKAY 2'h0
`define EBTC_RESP_SLVERR 2'h2
`endif

// File: ebtc_pkg.sv
/*
  Types of the eight-bit timer core: mode codes, bus carriers, state record.
  Assumes a 32-bit AXI4-Lite bus with 8-bit addresses.
*/
`default_nettype none
package ebtc_pkg;
  // Counting sequence selected by wave_mode
  typedef enum logic [2:0] {
    EBTC_NORMAL = 3'h0,
    EBTC_PHASE_FF = 3'h1,
    EBTC_CTC = 3'h2,
    EBTC_FAST_FF = 3'h3,
    EBTC_PHASE_OCR = 3'h5,
    EBTC_FAST_OCR = 3'h7
  } ebtc_mode_e;
  // Clock source codes of clock_select
  typedef enum logic [2:0] {
    EBTC_CS_STOP = 3'h0,
    EBTC_CS_DIV1 = 3'h1,
    EBTC_CS_DIV8 = 3'h2,
    EBTC_CS_DIV64 = 3'h3,
    EBTC_CS_DIV256 = 3'h4,
    EBTC_CS_DIV1024 = 3'h5,
    EBTC_CS_EXT_FALL = 3'h6,
    EBTC_CS_EXT_RISE = 3'h7
  } ebtc_cs_e;
  // Master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } ebtc_axi_req_s;
  // Slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ebtc_axi_rsp_s;
  // Pin side of the two wave channels
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } ebtc_pins_s;
  // Whole state of the timer
  typedef struct packed {
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [9:0] psc;
    logic [7:0] cnt;
    logic down;
    logic blk;
    logic [7:0] ocr_a;
    logic [7:0] ocr_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [1:0] wgm_lo;
    logic wgm_hi;
    logic [2:0] cs;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [2:0] msk;
    logic [2:0] flg;
    logic [1:0] pdir;
    logic [1:0] pval;
    logic pwr_off;
    logic wave_a;
    logic wave_b;
    ebtc_pins_s pins;
    logic [2:0] irq;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstb;
    ebtc_axi_rsp_s rsp;
  } ebtc_state_s;
endpackage
`default_nettype wire

// File: ebtc_pin_model.sv
/*
  Pin-side partner of the timer core: a pulse source on the external count
  input, and the pad levels of the two wave pins.
  Assumes a 100 MHz sys_clk and pull-ups on both wave pads.
*/
`default_nettype none
module ebtc_pin_model (
  input wire logic sys_clk,
  input wire ebtc_pkg::ebtc_pins_s wave_pins,
  output var logic ext_count_pin,
  output wire logic [1:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pad shows the driven value, or the pull-up level when it is not driven
  assign pad = (wave_pins.oe & wave_pins.out) | ~wave_pins.oe;
  // The count input idles low between bursts
  initial ext_count_pin = 1'b0;
  // Sends n rising edges that are wide enough for the two-flop synchroniser
  task automatic send_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    // Lets the last edge pass the synchroniser and reach the counter
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// File: ebtc_testbench.sv
/*
  Self-checking bench of the timer core: register tasks on AXI4-Lite,
  ticks from the external count pin, checks on flags, counts and pins.
  Assumes the pin partner model and the timer design are compiled first.
*/
`default_nettype none
`include "ebtc_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  ebtc_pkg::ebtc_axi_req_s axi_req = '0;
  ebtc_pkg::ebtc_axi_rsp_s axi_rsp;
  logic [2:0] irq_ack = 3'h0;
  logic [2:0] irq_req;
  ebtc_pkg::ebtc_pins_s wave_pins;
  logic ext_count_pin;
  logic [1:0] pad;
  int error_cnt = 0;
  int n_compared = 0;
  // Last read data and response code
  logic [31:0] rdat;
  logic [1:0] resp;
  // Byte strobes of the next write
  logic [3:0] wr_strb = 4'hF;
  // Output action steps on channel a: control_a value, force strobe, pin a
  logic [7:0] act_tab [6] = '{8'h40, 8'h80, 8'h40, 8'hC0, 8'h00, 8'h40};
  logic frc_tab [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic exp_tab [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

  // Clock of 10 ns period
  always #5 sys_clk = ~sys_clk;

  ebtc_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .ext_count_pin(ext_count_pin), .irq_ack(irq_ack), .irq_req(irq_req),
    .wave_pins(wave_pins));
  ebtc_pin_model pm (.sys_clk(sys_clk), .wave_pins(wave_pins),
    .ext_count_pin(ext_count_pin), .pad(pad));

  // Prints the verdict and ends the run
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A wait that ran out counts as a mismatch
  task automatic hang();
    error_cnt++;
    give_verdict();
  endtask
  // Compares a seen value with the expected one
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One register write; address and data are offered together
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    bit ok;
    ok = 1'b0;
    @(posedge sys_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= addr;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= data;
    axi_req.wstrb <= wr_strb;
    axi_req.bready <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge sys_clk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_req.bready && axi_rsp.bvalid) begin
        resp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        ok = 1'b1;
      end
    end
    if (!ok) hang();
  endtask
  // One register read
  task automatic rd(input logic [7:0] addr);
    bit ok;
    ok = 1'b0;
    @(posedge sys_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= addr;
    axi_req.rready <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge sys_clk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_req.rready && axi_rsp.rvalid) begin
        rdat = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        ok = 1'b1;
      end
    end
    if (!ok) hang();
  endtask
  // Reads a register and compares it
  task automatic rdc(input string what, input logic [7:0] addr, input logic [31:0] exp);
    rd(addr);
    check(what, rdat, exp);
  endtask
  // One-cycle service pulse on the acknowledge lines
  task automatic ack(input logic [2:0] b);
    @(posedge sys_clk);
    irq_ack <= b;
    @(posedge sys_clk);
    irq_ack <= 3'h0;
    @(posedge sys_clk);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check("pins at reset", {28'h0, wave_pins}, 32'h0);
    check("irq at reset", {29'h0, irq_req}, 32'h0);
    // Stopped timer ignores edges and keeps a written count
    wr(`EBTC_OFF_COUNT, 32'h55);
    pm.send_pulses(2);
    rdc("count stopped", `EBTC_OFF_COUNT, 32'h55);
    // Count up through the wrap on external rising edges
    wr(`EBTC_OFF_CMP_A, 32'h03);
    wr(`EBTC_OFF_CMP_B, 32'h40);
    wr(`EBTC_OFF_MASK, 32'h07);
    wr(`EBTC_OFF_COUNT, 32'hFE);
    wr(`EBTC_OFF_CTRL_B, 32'h07);
    pm.send_pulses(1);
    check("overflow early", {29'h0, irq_req}, 32'h0);
    pm.send_pulses(1);
    check("overflow", {29'h0, irq_req}, 32'h1);
    rdc("wrap", `EBTC_OFF_COUNT, 32'h00);
    // Match on compare_a, then clearing of flags
    pm.send_pulses(3);
    check("no match yet", {29'h0, irq_req}, 32'h1);
    pm.send_pulses(1);
    check("match a", {29'h0, irq_req}, 32'h3);
    wr(`EBTC_OFF_FLAG, 32'h0);
    rdc("flags kept", `EBTC_OFF_FLAG, 32'h3);
    wr(`EBTC_OFF_FLAG, 32'h1);
    rdc("overflow cleared", `EBTC_OFF_FLAG, 32'h2);
    ack(3'h2);
    check("serviced", {29'h0, irq_req}, 32'h0);
    // Count write while stopped blocks the match on the next tick only
    wr(`EBTC_OFF_CTRL_B, 32'h00);
    wr(`EBTC_OFF_CMP_B, 32'h20);
    wr(`EBTC_OFF_COUNT, 32'h20);
    wr(`EBTC_OFF_CTRL_B, 32'h07);
    pm.send_pulses(1);
    check("blocked", {29'h0, irq_req}, 32'h0);
    rdc("after block", `EBTC_OFF_COUNT, 32'h21);
    wr(`EBTC_OFF_COUNT, 32'h1F);
    pm.send_pulses(2);
    check("match b", {29'h0, irq_req}, 32'h4);
    ack(3'h4);
    check("serviced b", {29'h0, irq_req}, 32'h0);
    wr(`EBTC_OFF_FLAG, 32'h7);
    // Power-off bit freezes the counter
    wr(`EBTC_OFF_MISC, 32'h10);
    pm.send_pulses(2);
    rdc("power off", `EBTC_OFF_COUNT, 32'h21);
    // Port value shows while no action is set; undriven pads float high
    wr(`EBTC_OFF_CTRL_B, 32'h00);
    wr(`EBTC_OFF_MISC, 32'h08);
    check("port value", {28'h0, wave_pins}, 32'h8);
    check("pads off", {30'h0, pad}, 32'h3);
    // Actions on channel a through the force strobe, before the pins drive
    for (int i = 0; i < 6; i++) begin
      wr(`EBTC_OFF_CTRL_A, {24'h0, act_tab[i]});
      if (frc_tab[i]) wr(`EBTC_OFF_CTRL_B, 32'h80);
      check("wave a", {31'h0, wave_pins.out[0]}, {31'h0, exp_tab[i]});
    end
    wr(`EBTC_OFF_MISC, 32'h0B);
    check("pins on", {28'h0, wave_pins}, 32'hF);
    check("force no flag", {29'h0, irq_req}, 32'h0);
    rdc("force no count", `EBTC_OFF_COUNT, 32'h21);
    // Channel b clears over a high port value; direction still rules the pad
    wr(`EBTC_OFF_CTRL_A, 32'h60);
    wr(`EBTC_OFF_CTRL_B, 32'h40);
    check("override b", {28'h0, wave_pins}, 32'h7);
    check("pad driven low", {30'h0, pad}, 32'h1);
    wr(`EBTC_OFF_MISC, 32'h09);
    check("direction b", {28'h0, wave_pins}, 32'h5);
    check("pad pulled", {30'h0, pad}, 32'h3);
    // Mode change keeps the wave registers
    wr(`EBTC_OFF_CTRL_A, 32'h63);
    wr(`EBTC_OFF_CTRL_B, 32'h08);
    check("kept on mode", {28'h0, wave_pins}, 32'h5);
    rdc("mode low", `EBTC_OFF_CTRL_A, 32'h63);
    rdc("mode high", `EBTC_OFF_CTRL_B, 32'h08);
    // Actions set, normal mode still counts by one
    wr(`EBTC_OFF_CTRL_A, 32'hF0);
    wr(`EBTC_OFF_CTRL_B, 32'h07);
    wr(`EBTC_OFF_COUNT, 32'h10);
    pm.send_pulses(2);
    rdc("count with actions", `EBTC_OFF_COUNT, 32'h12);
    // A write without its low strobe is answered but ignored
    wr_strb = 4'hE;
    wr(`EBTC_OFF_COUNT, 32'h77);
    wr_strb = 4'hF;
    check("strobe resp", {30'h0, resp}, {30'h0, `EBTC_RESP_OKAY});
    rdc("strobe ignored", `EBTC_OFF_COUNT, 32'h12);
    // Unaligned write is refused
    wr(8'h09, 32'h33);
    check("unaligned resp", {30'h0, resp}, {30'h0, `EBTC_RESP_SLVERR});
    // Unmapped address
    rdc("unmapped data", 8'h20, 32'h0);
    check("unmapped resp", {30'h0, resp}, {30'h0, `EBTC_RESP_SLVERR});
    give_verdict();
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge sys_clk);
    hang();
  end
endmodule
`default_nettype wire
